// file: src/host_port_pkg.sv
`default_nettype none
package host_port_pkg;
   localparam int DATA_WIDTH      = 10;
   localparam int ADDR_WIDTH      = 2;
   localparam int CLK_PERIOD_NS   = 100;
   localparam int CONV_SETUP_NS   = 10;
   localparam int CONV_RELEASE_NS = 20;
   localparam int DIR_HOLD_NS     = 5;
   localparam logic [9:0] CTRL0_RESET     = 10'h000;
   localparam logic [9:0] CTRL1_RESET     = 10'h030;
   localparam int         DIR_MODE_BIT    = 6;
   localparam logic [1:0] CTRL0_ADDR      = 2'h0;
   localparam logic [1:0] CTRL1_ADDR      = 2'h1;

   typedef struct packed {
      logic chip_sel_low_n;
      logic chip_sel_high;
      logic rd_n;
      logic wr_n;
   } bus_ctrl_type;

   typedef struct packed {
      logic rd_int;
      logic wr_int;
   } strobe_type;
endpackage : host_port_pkg
`default_nettype wire

// file: src/adc_host_bus_strobe_logic.sv
`default_nettype none
// Function
// - Write pin can act as combined read/write direction input.
// - Read strobe: both selects and read active, write inactive.
// - Read strobe rises when the last qualifying input becomes active.
// - Read strobe drops when the first qualifying input goes inactive.
// - Data buffers driven with result from the clock edge that samples read strobe active.
// - Write strobe: both selects and write active, read inactive.
// - Write strobe drops when first select or write goes inactive.
// - Write strobe loads data into addressed control register 0 or 1.
// - Control writes loaded only at a rising clk edge with write strobe active.
// - Direction mode: high means read, low write, read pin ignored.
// - Mode bit cleared at reset: separate read and write strobes.
module adc_host_bus_strobe_logic #(
   parameter int DATA_WIDTH = host_port_pkg::DATA_WIDTH
) (
   input  wire logic                                 clk,
   input  wire logic                                 rst,
   input  wire host_port_pkg::bus_ctrl_type          bus_ctrl,
   input  wire logic [host_port_pkg::ADDR_WIDTH-1:0] reg_addr,
   input  wire logic [DATA_WIDTH-1:0]                data_in,
   input  wire logic [DATA_WIDTH-1:0]                result_word,
   output logic      [DATA_WIDTH-1:0]                data_out,
   output logic                                      data_oe_n,
   output logic      [DATA_WIDTH-1:0]                ctrl0,
   output logic      [DATA_WIDTH-1:0]                ctrl1,
   output host_port_pkg::strobe_type                 strobes
);
   logic                  dir_mode;
   logic                  sel_active;
   logic                  rd_req;
   logic                  wr_req;
   logic                  wr_prev_q;
   logic                  wr_prev_d;
   logic [DATA_WIDTH-1:0] ctrl0_q;
   logic [DATA_WIDTH-1:0] ctrl0_d;
   logic [DATA_WIDTH-1:0] ctrl1_q;
   logic [DATA_WIDTH-1:0] ctrl1_d;
   logic [DATA_WIDTH-1:0] data_q;
   logic [DATA_WIDTH-1:0] data_d;
   logic                  oe_n_q;
   logic                  oe_n_d;

   assign dir_mode   = ctrl1_q[host_port_pkg::DIR_MODE_BIT];
   assign sel_active = !bus_ctrl.chip_sel_low_n && bus_ctrl.chip_sel_high;

   always_comb begin
      if (dir_mode) begin
         rd_req = sel_active && bus_ctrl.wr_n;
         wr_req = sel_active && !bus_ctrl.wr_n;
      end else begin
         rd_req = sel_active && !bus_ctrl.rd_n && bus_ctrl.wr_n;
         wr_req = sel_active && !bus_ctrl.wr_n && bus_ctrl.rd_n;
      end
   end

   // Strobes follow last arrival and first departure
   assign strobes = '{rd_int: rd_req, wr_int: wr_req};

   always_comb begin
      wr_prev_d = wr_req;
      ctrl0_d   = ctrl0_q;
      ctrl1_d   = ctrl1_q;
      data_d    = rd_req ? result_word : data_q;
      oe_n_d    = !rd_req;
      if (wr_req) begin
         if (reg_addr == host_port_pkg::CTRL0_ADDR) begin
            ctrl0_d = data_in;
         end else if (reg_addr == host_port_pkg::CTRL1_ADDR) begin
            ctrl1_d = data_in;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_prev_q <= 1'b0;
         ctrl0_q   <= host_port_pkg::CTRL0_RESET;
         ctrl1_q   <= host_port_pkg::CTRL1_RESET;
         data_q    <= '0;
         oe_n_q    <= 1'b1;
      end else begin
         wr_prev_q <= wr_prev_d;
         ctrl0_q   <= ctrl0_d;
         ctrl1_q   <= ctrl1_d;
         data_q    <= data_d;
         oe_n_q    <= oe_n_d;
      end
   end

   assign data_out  = data_q;
   assign data_oe_n = oe_n_q;
   assign ctrl0     = ctrl0_q;
   assign ctrl1     = ctrl1_q;

   // Read data driven one edge after strobe
   chk_read_gate: assert property (
      @(posedge clk) disable iff (rst)
      strobes.rd_int
      |=> !data_oe_n && data_out == $past(result_word)
   ) else $error("read not driven");

   // Buffers released without read strobe
   chk_idle_hiz: assert property (
      @(posedge clk) disable iff (rst)
      !strobes.rd_int
      |=> data_oe_n
   ) else $error("bus driven idle");

   // Read only with both selects
   chk_rd_needs_sel: assert property (
      @(posedge clk) disable iff (rst)
      strobes.rd_int
      |-> sel_active
   ) else $error("read without select");

   // Separate mode read decode
   chk_sep_rd_pin: assert property (
      @(posedge clk) disable iff (rst)
      !dir_mode && sel_active && !bus_ctrl.rd_n && bus_ctrl.wr_n
      |-> strobes.rd_int
   ) else $error("separate read missed");

   // First inactive select drops both strobes
   chk_rd_drop: assert property (
      @(posedge clk) disable iff (rst)
      !sel_active
      |-> !strobes.rd_int && !strobes.wr_int
   ) else $error("strobe without select");

   // Never both strobes
   chk_no_both: assert property (
      @(posedge clk) disable iff (rst)
      1'b1
      |-> !(strobes.rd_int && strobes.wr_int)
   ) else $error("both strobes");

   // Write only with selects and write level
   chk_wr_needs_sel: assert property (
      @(posedge clk) disable iff (rst)
      strobes.wr_int
      |-> sel_active && !bus_ctrl.wr_n
   ) else $error("write without select");

   // Register 0 load
   chk_wr_ctrl0: assert property (
      @(posedge clk) disable iff (rst)
      strobes.wr_int && reg_addr == host_port_pkg::CTRL0_ADDR
      |=> ctrl0 == $past(data_in)
   ) else $error("ctrl0 not loaded");

   // Register 1 load
   chk_wr_ctrl1: assert property (
      @(posedge clk) disable iff (rst)
      strobes.wr_int && reg_addr == host_port_pkg::CTRL1_ADDR
      |=> ctrl1 == $past(data_in)
   ) else $error("ctrl1 not loaded");

   // Unused addresses leave both registers
   chk_bad_addr: assert property (
      @(posedge clk) disable iff (rst)
      strobes.wr_int && reg_addr[1]
      |=> $stable(ctrl0) && $stable(ctrl1)
   ) else $error("stray register write");

   // Direction mode read decode
   chk_rd_ignored: assert property (
      @(posedge clk) disable iff (rst)
      dir_mode && sel_active && bus_ctrl.wr_n
      |-> strobes.rd_int
   ) else $error("dir read missed");

   // Direction mode write decode
   chk_dir_write: assert property (
      @(posedge clk) disable iff (rst)
      dir_mode && sel_active && !bus_ctrl.wr_n
      |-> strobes.wr_int
   ) else $error("dir write missed");

   // Register 1 holds without write strobe
   chk_stable_regs: assert property (
      @(posedge clk) disable iff (rst)
      !strobes.wr_int
      |=> $stable(ctrl1)
   ) else $error("ctrl1 changed");

   // Register 0 holds without write strobe
   chk_stable_ctrl0: assert property (
      @(posedge clk) disable iff (rst)
      !strobes.wr_int
      |=> $stable(ctrl0)
   ) else $error("ctrl0 changed");

   // Mode bit clear after reset
   chk_reset_mode: assert property (
      @(posedge clk)
      $past(rst)
      |-> !dir_mode
   ) else $error("mode not cleared");

   cov_read: cover property (
      @(posedge clk) disable iff (rst)
      strobes.rd_int ##1 !strobes.rd_int
   );

   cov_write: cover property (
      @(posedge clk) disable iff (rst)
      strobes.wr_int
   );

   cov_dir_read: cover property (
      @(posedge clk) disable iff (rst)
      dir_mode && strobes.rd_int
   );

   cov_write_end: cover property (
      @(posedge clk) disable iff (rst)
      wr_prev_q && !strobes.wr_int
   );

endmodule : adc_host_bus_strobe_logic
`default_nettype wire

// file: tb/host_model.sv
`default_nettype none
module host_model (
   input  wire logic                  clk,
   output host_port_pkg::bus_ctrl_type bus_ctrl,
   output logic [1:0]                 reg_addr,
   output logic [9:0]                 data_in
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      bus_ctrl = 4'hB;
      reg_addr = 2'h0;
      data_in  = 10'h3FF;
   end
   // One bus cycle; inputs change 1 ns after the rising clock edge
   task automatic cyc(input logic [3:0] c, input logic [1:0] a, input logic [9:0] d);
      @(posedge clk) #1;
      bus_ctrl = c;
      reg_addr = a;
      data_in  = d;
   endtask : cyc
endmodule : host_model
`default_nettype wire

// file: tb/adc_host_bus_strobe_logic_tb.sv
`default_nettype none
module adc_host_bus_strobe_logic_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic                        clk, rst, data_oe_n;
   host_port_pkg::bus_ctrl_type bus_ctrl;
   host_port_pkg::strobe_type   strobes;
   logic [1:0]                  reg_addr;
   logic [9:0]                  data_in, data_out, ctrl0, ctrl1, result_word;
   int                          bad_count = 0, n_checks = 0;
   host_model i_host_model (.clk(clk), .bus_ctrl(bus_ctrl), .reg_addr(reg_addr), .data_in(data_in));
   adc_host_bus_strobe_logic i_adc_host_bus_strobe_logic (.clk(clk), .rst(rst), .bus_ctrl(bus_ctrl),
      .reg_addr(reg_addr), .data_in(data_in), .result_word(result_word), .data_out(data_out),
      .data_oe_n(data_oe_n), .ctrl0(ctrl0), .ctrl1(ctrl1), .strobes(strobes));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic cyc(input logic [3:0] c, input logic [1:0] a, input logic [9:0] d);
      i_host_model.cyc(c, a, d);
   endtask : cyc
   task automatic sweep(input logic m);
      logic [1:0] e;
      for (int c = 0; c < 16; c++) begin
         cyc(c[3:0], 2'h2, 10'h3FF);
         #1;
         e[1] = !c[3] && c[2] && c[0] && (m || !c[1]);
         e[0] = !c[3] && c[2] && !c[0] && (m || c[1]);
         chk("strobes", {8'h00, e}, {8'h00, strobes});
      end
      $display("sweep mode %0d done", m);
   endtask : sweep
   task automatic wr_reg(input logic [1:0] a, input logic [9:0] d);
      cyc(4'h6, a, d);
      cyc(4'hB, 2'h0, ~d);
   endtask : wr_reg
   task automatic rd_test;
      cyc(4'h5, 2'h0, 10'h000);
      cyc(4'hB, 2'h0, 10'h3FF);
      chk("data_oe_n", 10'h000, {9'h000, data_oe_n});
      chk("data_out", result_word, data_out);
      cyc(4'hB, 2'h0, 10'h000);
      chk("data_oe_n", 10'h001, {9'h000, data_oe_n});
      $display("read done");
   endtask : rd_test
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report
   initial begin
      rst = 1'b1;
      result_word = 10'h2A5;
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      sweep(1'b0);
      chk("ctrl0", 10'h000, ctrl0);
      chk("ctrl1", 10'h030, ctrl1);
      rd_test();
      wr_reg(2'h0, 10'h155);
      wr_reg(2'h1, 10'h070);
      chk("ctrl0", 10'h155, ctrl0);
      chk("ctrl1", 10'h070, ctrl1);
      sweep(1'b1);
      wr_reg(2'h1, 10'h030);
      chk("ctrl1", 10'h030, ctrl1);
      final_report();
   end
endmodule : adc_host_bus_strobe_logic_tb
`default_nettype wire
